// [rtl/xrip_pkg.sv]
/*
  Constants for the extended SRAM indirect port: bus offsets, widths and
  pointer reset value.
  Assumes a byte-wide host bus with a 5-bit address.
*/
package xrip_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 8;
  localparam int unsigned DEPTH = 256;
  localparam logic [ADDR_W-1:0] OFS_POINTER = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_DATA_WINDOW = 5'h13;
  localparam logic [PTR_W-1:0] PTR_LOWEST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_HIGHEST = 8'hFF;
  localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_IDLE = 8'h00;
  typedef enum logic [1:0] {
    XRIP_IDLE = 2'b00,
    XRIP_READ = 2'b01,
    XRIP_WRITE = 2'b10
  } xrip_cycle_t;
endpackage : xrip_pkg

// [rtl/xrip_sram.sv]
/*
  256 x 8 storage array with registered read data.
  Assumes one synchronous clock; write and read addresses share one port.
*/
`timescale 1ns/1ps
module xrip_sram (
  // clock
  input wire logic clk_sys_in,
  // access
  input wire logic [xrip_pkg::PTR_W-1:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [xrip_pkg::DATA_W-1:0] wr_data_in,
  output logic [xrip_pkg::DATA_W-1:0] rd_data_out
);
  import xrip_pkg::*;

  logic [DATA_W-1:0] mem_reg [0:DEPTH-1];
  logic [DATA_W-1:0] rd_data_reg;

  // contents are battery backed in the real part, so no reset here
  always_ff @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem_reg[addr_in] <= wr_data_in;
    end
    rd_data_reg <= mem_reg[addr_in];
  end

  assign rd_data_out = rd_data_reg;
endmodule : xrip_sram

// [rtl/xrip_port.sv]
/*
  Extended SRAM indirect port: pointer latch at 10h, data window at 13h,
  optional burst advance of the pointer.
  Assumes the host strobes are asynchronous pins; each is passed through
  two flip-flops and an access is acted on per bus cycle.
*/
// Overview of operation
// - 256-byte array addressed by an 8-bit pointer, 00h through FFh.
// - host write to 10h loads the pointer.
// - host read of 13h returns the byte at the pointer.
// - host write to 13h stores the byte at the pointer.
// - without burst, data-window accesses leave the pointer alone.
// - burst advance only while burst_increment_enable is one.
// - in burst, pointer increments when a 13h access ends; others never.
// - increment from FFh wraps to 00h.
`timescale 1ns/1ps
module xrip_port (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // host bus pins
  input wire logic ce_b_in,
  input wire logic oe_b_in,
  input wire logic we_b_in,
  input wire logic [xrip_pkg::ADDR_W-1:0] addr_in,
  input wire logic [xrip_pkg::DATA_W-1:0] data_in,
  output logic [xrip_pkg::DATA_W-1:0] data_out,
  output logic data_oe_b_out,
  // control
  input wire logic burst_increment_enable_in,
  output logic [xrip_pkg::PTR_W-1:0] pointer_out
);
  import xrip_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] strb_s1_reg, strb_s2_reg;
  logic [ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
  logic [DATA_W-1:0] data_s1_reg, data_s2_reg;
  logic burst_s1_reg, burst_s2_reg;
  logic [2:0] strb_s1_next, strb_s2_next;
  logic [ADDR_W-1:0] addr_s1_next, addr_s2_next;
  logic [DATA_W-1:0] data_s1_next, data_s2_next;
  logic burst_s1_next, burst_s2_next;

  // only the second stage feeds logic; the first may still be settling
  always_comb begin
    strb_s1_next = {ce_b_in, oe_b_in, we_b_in};
    strb_s2_next = strb_s1_reg;
    addr_s1_next = addr_in;
    addr_s2_next = addr_s1_reg;
    data_s1_next = data_in;
    data_s2_next = data_s1_reg;
    burst_s1_next = burst_increment_enable_in;
    burst_s2_next = burst_s1_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      // idle-high strobes, so leaving reset starts no false cycle
      strb_s1_reg <= 3'h7;
      strb_s2_reg <= 3'h7;
      addr_s1_reg <= 5'h00;
      addr_s2_reg <= 5'h00;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
      burst_s1_reg <= 1'b0;
      burst_s2_reg <= 1'b0;
    end else begin
      strb_s1_reg <= strb_s1_next;
      strb_s2_reg <= strb_s2_next;
      addr_s1_reg <= addr_s1_next;
      addr_s2_reg <= addr_s2_next;
      data_s1_reg <= data_s1_next;
      data_s2_reg <= data_s2_next;
      burst_s1_reg <= burst_s1_next;
      burst_s2_reg <= burst_s2_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoding shared by the cycle tracker and the read drive

  // write wins when we and oe are both low, so the bus is never driven
  // against a host that is still writing
  function automatic xrip_cycle_t strobe_decode(input logic ce, input logic oe,
    input logic we);
    xrip_cycle_t kind;
    kind = XRIP_IDLE;
    if (ce && we) begin
      kind = XRIP_WRITE;
    end else if (ce && oe) begin
      kind = XRIP_READ;
    end
    return kind;
  endfunction : strobe_decode

  function automatic logic is_pointer_ofs(input logic [ADDR_W-1:0] a);
    return a == OFS_POINTER;
  endfunction : is_pointer_ofs

  function automatic logic is_window_ofs(input logic [ADDR_W-1:0] a);
    return a == OFS_DATA_WINDOW;
  endfunction : is_window_ofs

  function automatic logic [PTR_W-1:0] ptr_advance(input logic [PTR_W-1:0] p);
    // FFh wraps to 00h
    return (p == PTR_HIGHEST) ? PTR_LOWEST : p + 8'h01;
  endfunction : ptr_advance

  // strobes are active low: ce in bit 2, oe in bit 1, we in bit 0
  logic ce_act, oe_act, we_act;
  xrip_cycle_t strb_kind;
  assign ce_act = !strb_s2_reg[2];
  assign oe_act = !strb_s2_reg[1];
  assign we_act = !strb_s2_reg[0];
  assign strb_kind = strobe_decode(ce_act, oe_act, we_act);

  ////////////////////////////////////////////////////////////////////
  // bus cycle tracking
  // address taken at cycle entry, so a late address change is ignored
  xrip_cycle_t cyc_reg, cyc_next;
  logic [ADDR_W-1:0] cyc_addr_reg, cyc_addr_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic doe_b_reg, doe_b_next;
  logic mem_we;
  logic [DATA_W-1:0] mem_rd;

  always_comb begin
    cyc_next = cyc_reg;
    cyc_addr_next = cyc_addr_reg;
    ptr_next = ptr_reg;
    mem_we = 1'b0;
    case (cyc_reg)
      XRIP_IDLE: begin
        if (strb_kind != XRIP_IDLE) begin
          cyc_next = strb_kind;
          cyc_addr_next = addr_s2_reg;
        end
      end
      XRIP_READ, XRIP_WRITE: begin
        // cycle ends when strb_kind first returns to XRIP_IDLE; a single exit means one
        // increment even when several strobes rise together
        if (strb_kind == XRIP_IDLE) begin
          cyc_next = XRIP_IDLE;
          if (cyc_reg == XRIP_WRITE) begin
            // data taken at strobe end, the moment a latch would close
            if (is_pointer_ofs(cyc_addr_reg)) begin
              ptr_next = data_s2_reg;
            end else if (is_window_ofs(cyc_addr_reg)) begin
              mem_we = 1'b1;
            end
          end
          // the array writes at the old pointer on the edge that steps it
          if (is_window_ofs(cyc_addr_reg) && burst_s2_reg) begin
            ptr_next = ptr_advance(ptr_reg);
          end
        end
      end
      default: begin
        cyc_next = XRIP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cyc_reg <= XRIP_IDLE;
      cyc_addr_reg <= 5'h00;
      // reset value is arbitrary; the array keeps its contents
      ptr_reg <= PTR_RESET;
    end else begin
      cyc_reg <= cyc_next;
      cyc_addr_reg <= cyc_addr_next;
      ptr_reg <= ptr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // storage, addressed by the pointer
  // one address port: reads always follow the pointer, so a read of 13h
  // just after a pointer change shows the new byte one edge late
  xrip_sram u_sram (
    .clk_sys_in(clk_sys_in),
    .addr_in(ptr_reg),
    .wr_en_in(mem_we),
    .wr_data_in(data_s2_reg),
    .rd_data_out(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////
  // read data drive
  // other offsets are not ours: leave the bus released and idle
  always_comb begin
    dout_next = DATA_IDLE;
    doe_b_next = 1'b1;
    if (strb_kind == XRIP_READ) begin
      if (is_pointer_ofs(addr_s2_reg)) begin
        dout_next = ptr_reg;
        doe_b_next = 1'b0;
      end else if (is_window_ofs(addr_s2_reg)) begin
        dout_next = mem_rd;
        doe_b_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      dout_reg <= DATA_IDLE;
      doe_b_reg <= 1'b1;
    end else begin
      dout_reg <= dout_next;
      doe_b_reg <= doe_b_next;
    end
  end

  // every output straight from a register
  assign data_out = dout_reg;
  assign data_oe_b_out = doe_b_reg;
  assign pointer_out = ptr_reg;
endmodule : xrip_port

// [verif/xrip_port_properties.sv]
/* Checker on xrip_port pins.
   Assumes the host holds pins stable around strobes. */
`timescale 1ns/1ps
module xrip_chk import xrip_pkg::*; (
  input wire logic clk_sys_in, rst_b_in, ce_b_in, oe_b_in, we_b_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in, data_out,
  input wire logic data_oe_b_out, burst_increment_enable_in,
  input wire logic [PTR_W-1:0] pointer_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // pins 1..3 edges back, same lag as the design sync
  logic [16:0] c1, c2, c3;
  always_ff @(posedge clk_sys_in) {c3, c2, c1} <= {c2, c1, ce_b_in, oe_b_in, we_b_in,
    addr_in, data_in, burst_increment_enable_in};
  wire sw = !c2[16] & !c2[14], sr = !c2[16] & !c2[15] & c2[14];
  wire pw = !c3[16] & !c3[14], pe = !c3[16] & !(c3[14] & c3[15]) & !sw & !sr;
  wire [4:0] sa = c2[13:9], pa = c3[13:9];
  wire e13 = pe & pa == OFS_DATA_WINDOW, e10 = pe & pw & pa == OFS_POINTER;
  wire eo = pe & !e10 & !(e13 & c2[0]);
  wire rok = sr & (sa == OFS_POINTER | sa == OFS_DATA_WINDOW);
  AST_PTR_LOAD: assert property (e10 |-> ##[1:3] pointer_out == c3[8:1])
    else $error("pointer not loaded");
  AST_PTR_INC: assert property (e13 && c2[0] |=>
    pointer_out == $past(pointer_out) + 8'h01) else $error("burst step wrong");
  AST_PTR_HOLD: assert property (eo |=> $stable(pointer_out) [*3])
    else $error("pointer moved");
  AST_ONE_STEP: assert property ($changed(pointer_out) |=> $stable(pointer_out) [*3])
    else $error("pointer stepped twice");
  AST_RD_STANDS: assert property ((sr && sa == OFS_DATA_WINDOW) [*4] |-> !data_oe_b_out)
    else $error("read not driven");
  AST_RD_CAUSE: assert property ($fell(data_oe_b_out) |-> $past(rok))
    else $error("drive without read");
  AST_WR_QUIET: assert property (sw && pw |-> data_oe_b_out)
    else $error("drive in write");
  AST_PTR_READ: assert property (!data_oe_b_out && sa == OFS_POINTER && pa == OFS_POINTER
    |-> data_out == pointer_out) else $error("pointer readback wrong");
  cover property (e13 && c3[0] && pointer_out == PTR_HIGHEST);
  cover property (e10);
  cover property (e13 && !c3[0]);
endmodule : xrip_chk
bind xrip_port xrip_chk u_chk (.clk_sys_in, .rst_b_in, .ce_b_in, .oe_b_in, .we_b_in,
  .addr_in, .data_in, .data_out, .data_oe_b_out, .burst_increment_enable_in, .pointer_out);

// [verif/xrip_host.sv]
/* Host processor model driving the byte bus.
   Assumes one task call at a time. */
`timescale 1ns/1ps
module xrip_host import xrip_pkg::*; (
  input wire logic clk_sys_in,
  output logic ce_b_out, oe_b_out, we_b_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] data_out,
  input wire logic [DATA_W-1:0] rd_data_in,
  input wire logic rd_oe_b_in
);
  initial {ce_b_out, oe_b_out, we_b_out, addr_out, data_out} = 16'hE000;
  task automatic cyc(input logic [4:0] a, input logic [7:0] d, input logic w,
    output logic [7:0] q);
    q = 'x;
    @(negedge clk_sys_in) {addr_out, data_out} = {a, d};
    repeat (3) @(negedge clk_sys_in);
    {ce_b_out, oe_b_out, we_b_out} = {1'b0, w, !w};
    // sample half a cycle after each edge, where read data have settled
    repeat (6) @(negedge clk_sys_in) if (!w && !rd_oe_b_in) q = rd_data_in;
    {ce_b_out, oe_b_out, we_b_out} = 3'b111;
    repeat (3) @(negedge clk_sys_in);
    // released bus must not look like the last byte
    data_out = ~data_out;
    repeat (2) @(negedge clk_sys_in);
  endtask : cyc
endmodule : xrip_host

// [verif/tb_top.sv]
/* Bench for xrip_port.
   Assumes two-stage pin synchronisers inside the design. */
`timescale 1ns/1ps
module tb_top;
  import xrip_pkg::*;
  logic clk_sys_in = 0, rst_b_in = 0, be = 0, ce_b, oe_b, we_b, oe_q;
  logic [4:0] a;
  logic [7:0] d, rd, ptr;
  int fails = 0, compares = 0;
  initial forever #50 clk_sys_in = ~clk_sys_in;
  xrip_host host (.clk_sys_in, .ce_b_out(ce_b), .oe_b_out(oe_b), .we_b_out(we_b),
    .addr_out(a), .data_out(d), .rd_data_in(rd), .rd_oe_b_in(oe_q));
  xrip_port dut (.clk_sys_in, .rst_b_in, .ce_b_in(ce_b), .oe_b_in(oe_b), .we_b_in(we_b),
    .addr_in(a), .data_in(d), .data_out(rd), .data_oe_b_out(oe_q),
    .burst_increment_enable_in(be), .pointer_out(ptr));
  task automatic chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic t_single;
    logic [7:0] r;
    host.cyc(OFS_POINTER, 8'h3C, 1'b1, r);
    host.cyc(OFS_POINTER, 8'h00, 1'b0, r);
    chk(r, 8'h3C);
    host.cyc(OFS_DATA_WINDOW, 8'hA5, 1'b1, r);
    repeat (2) begin
      host.cyc(OFS_DATA_WINDOW, 8'h00, 1'b0, r);
      chk(r, 8'hA5);
    end
    chk(ptr, 8'h3C);
    host.cyc(5'h11, 8'h77, 1'b1, r);
    host.cyc(5'h11, 8'h00, 1'b0, r);
    chk(r, 8'hXX);
    chk(ptr, 8'h3C);
    $display("single done");
  endtask : t_single
  task automatic t_burst;
    logic [7:0] r;
    @(negedge clk_sys_in) be = 1'b1;
    for (int m = 0; m < 2; m++) begin
      host.cyc(OFS_POINTER, PTR_HIGHEST - 8'h01, 1'b1, r);
      for (int i = 0; i < 3; i++) begin
        host.cyc(OFS_DATA_WINDOW, 8'h11 * (i + 1), m == 0, r);
        if (m == 1) chk(r, 8'h11 * (i + 1));
        chk(ptr, PTR_HIGHEST + i[7:0]);
      end
      host.cyc(OFS_POINTER, 8'h00, 1'b0, r);
      chk(r, 8'h01);
      chk(ptr, 8'h01);
    end
    @(negedge clk_sys_in) be = 1'b0;
    $display("burst done");
  endtask : t_burst
  task automatic t_reset;
    logic [7:0] r;
    host.cyc(OFS_POINTER, 8'h5A, 1'b1, r);
    chk(ptr, 8'h5A);
    @(negedge clk_sys_in) rst_b_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk(ptr, PTR_RESET);
    chk(rd, DATA_IDLE);
    chk({7'h00, oe_q}, 8'h01);
    host.cyc(OFS_POINTER, 8'h00, 1'b0, r);
    chk(r, PTR_RESET);
    $display("reset done");
  endtask : t_reset
  initial begin
    repeat (8) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk(ptr, PTR_RESET);
    t_single();
    t_burst();
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    give_verdict();
  end
endmodule : tb_top
